/* File: amd_pkg.sv */
/*
 * constants, types and register map of the channel-address decode block.
 * assumes a single 100 MHz pclk domain and an APB master in front of it.
 */
//
// Function
// - first result after power-up is invalid and must be discarded
// - address order: power-up, single/diff, odd/sign, group-high, group-low
// - power-up bit 0 powers down and disconnects every channel
// - single-ended: positive channel {high,low,odd}, negative is the common terminal
// - differential: pair (2k,2k+1); odd/sign picks which side is positive
package amd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] AMD_OFF_ADDR   = 8'h00;
  localparam logic [7:0] AMD_OFF_STATUS = 8'h04;
  localparam logic [7:0] AMD_OFF_SELECT = 8'h08;
  localparam logic [7:0] AMD_OFF_COUNT  = 8'h0c;

  localparam logic [4:0] AMD_ADDR_RESET = 5'h00;

  // status bits
  localparam int AMD_ST_INIT_DONE = 0;
  localparam int AMD_ST_FIRST     = 1;
  localparam int AMD_ST_DISCARDED = 2;
  localparam int AMD_ST_CS_HIGH   = 3;

  // select register fields
  localparam int AMD_SEL_POS_LSB = 0;
  localparam int AMD_SEL_NEG_LSB = 8;
  localparam int AMD_SEL_CMN_BIT = 16;
  localparam int AMD_SEL_PD_BIT  = 17;

  localparam int AMD_CHANNELS = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int AMD_CLK_NS            = 10;
  localparam int AMD_CONV_CLK_NS       = 400;
  localparam int AMD_SEL_HIGH_CONV_CLK = 1;
  localparam int AMD_SEL_HIGH_CYCLES   =
    (AMD_SEL_HIGH_CONV_CLK * AMD_CONV_CLK_NS + AMD_CLK_NS - 1) / AMD_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic group_select_low;
    logic group_select_high;
    logic odd_or_sign;
    logic single_or_differential;
    logic power_up_control;
  } amd_addr_type;

  typedef struct packed {
    logic       pwr_dn;
    logic       cmn_neg;
    logic [7:0] neg;
    logic [7:0] pos;
  } amd_sel_type;

  typedef enum logic [2:0] {
    AMD_WAIT_HIGH = 3'b001,
    AMD_FIRST     = 3'b010,
    AMD_RUN       = 3'b100
  } amd_state_type;

endpackage

/* File: amd_sync.sv */
/*
 * two-flop synchroniser for pin inputs.
 * assumes the pins are asynchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none
module amd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("amd_sync: WIDTH must be at least 1");
  end

  // first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // amd_sync
`default_nettype wire

/* File: amd_mux_decode.sv */
/*
 * combinational decode of the five-bit channel address into input switches.
 * assumes eight analog inputs plus a common terminal.
 */
`timescale 1ns/1ns
`default_nettype none
module amd_mux_decode (
  input  wire amd_pkg::amd_addr_type addr,
  output var  amd_pkg::amd_sel_type  sel
);

  function automatic logic [7:0] amd_onehot(input logic [2:0] idx);
    amd_onehot = 8'h01 << idx;
  endfunction

  always_comb begin
    sel = '0;
    if (!addr.power_up_control) begin
      sel.pwr_dn = 1'b1;
    end else if (addr.single_or_differential) begin
      sel.pos     = amd_onehot({addr.group_select_high, addr.group_select_low,
                                addr.odd_or_sign});
      sel.cmn_neg = 1'b1;
    end else begin
      // pair (2k, 2k+1), odd side positive when odd/sign is set
      sel.pos = amd_onehot({addr.group_select_high, addr.group_select_low,
                            addr.odd_or_sign});
      sel.neg = amd_onehot({addr.group_select_high, addr.group_select_low,
                            ~addr.odd_or_sign});
    end
  end

endmodule // amd_mux_decode
`default_nettype wire

/* File: amd_top.sv */
/*
 * channel-address decode and start-up supervision, APB register slave.
 * assumes conv_done comes from the sequencer on pclk, select_n from a pin.
 */
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module amd_top #(
  parameter int AW     = 12,
  parameter int CNT_W  = 16,
  parameter int HIGH_W = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  input  wire logic          select_n,
  input  wire logic          conv_done,
  output var  logic [7:0]    chan_pos_en,
  output var  logic [7:0]    chan_neg_en,
  output var  logic          common_terminal_neg,
  output var  logic          powered_down,
  output var  logic          init_done,
  output var  logic          result_keep
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  initial begin
    if (AW < 8) $error("amd_top: AW must be at least 8");
    if (CNT_W < 1 || CNT_W > 32) $error("amd_top: CNT_W out of range");
    if ((1 << HIGH_W) <= amd_pkg::AMD_SEL_HIGH_CYCLES) begin
      $error("amd_top: HIGH_W too narrow for select-high interval");
    end
  end

  localparam logic [HIGH_W-1:0] HIGH_TARGET = HIGH_W'(amd_pkg::AMD_SEL_HIGH_CYCLES);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  amd_pkg::amd_addr_type  addr_reg;
  amd_pkg::amd_sel_type   sel_next;
  amd_pkg::amd_sel_type   sel_reg;
  amd_pkg::amd_state_type state_reg;
  amd_pkg::amd_state_type state_next;
  logic [HIGH_W-1:0]      high_cnt_reg;
  logic [CNT_W-1:0]       count_reg;
  logic                   discarded_reg;
  logic                   select_n_sync;
  logic                   wr_en;
  logic                   rd_en;
  logic                   hit_addr;
  logic                   hit_status;
  logic                   hit_select;
  logic                   hit_count;
  logic                   hit_any;
  logic                   first_done;
  logic [31:0]            rd_mux;
  logic [HIGH_W-1:0]      high_run_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and decode

  amd_sync #(
    .WIDTH (1)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (select_n),
    .sync_out (select_n_sync)
  );

  amd_mux_decode u_decode (
    .addr (addr_reg),
    .sel  (sel_next)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  function automatic logic amd_hit(input logic [AW-1:0] a, input logic [7:0] off);
    amd_hit = (a[AW-1:8] == '0) && (a[7:0] == off);
  endfunction

  assign hit_addr   = amd_hit(paddr, amd_pkg::AMD_OFF_ADDR);
  assign hit_status = amd_hit(paddr, amd_pkg::AMD_OFF_STATUS);
  assign hit_select = amd_hit(paddr, amd_pkg::AMD_OFF_SELECT);
  assign hit_count  = amd_hit(paddr, amd_pkg::AMD_OFF_COUNT);
  assign hit_any    = hit_addr | hit_status | hit_select | hit_count;

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign wr_en   = psel & penable & pwrite & hit_any;
  assign rd_en   = psel & penable & ~pwrite & hit_any;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_addr) begin
      rd_mux[4:0] = addr_reg;
    end
    if (hit_status) begin
      rd_mux[amd_pkg::AMD_ST_INIT_DONE] = (state_reg != amd_pkg::AMD_WAIT_HIGH);
      rd_mux[amd_pkg::AMD_ST_FIRST]     = (state_reg == amd_pkg::AMD_FIRST);
      rd_mux[amd_pkg::AMD_ST_DISCARDED] = discarded_reg;
      rd_mux[amd_pkg::AMD_ST_CS_HIGH]   = select_n_sync;
    end
    if (hit_select) begin
      rd_mux[amd_pkg::AMD_SEL_PD_BIT:amd_pkg::AMD_SEL_POS_LSB] = sel_reg;
    end
    if (hit_count) begin
      rd_mux[CNT_W-1:0] = count_reg;
    end
  end

  // read data from a flop, refreshed only in the setup cycle of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end else if (rd_en) begin
      prdata <= prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel address register, bit 0 is power-up control

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= amd_pkg::AMD_ADDR_RESET;
    end else if (wr_en && hit_addr && pstrb[0]) begin
      addr_reg <= pwdata[4:0];
    end
  end

  // switches change only from flops, no glitch on the analog side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= '{pwr_dn: 1'b1, default: '0};
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign chan_pos_en         = sel_reg.pos;
  assign chan_neg_en         = sel_reg.neg;
  assign common_terminal_neg = sel_reg.cmn_neg;
  assign powered_down        = sel_reg.pwr_dn;

  ////////////////////////////////////////////////////////////////////////////////
  // start-up supervision

  // select may have been low through the supply ramp, so always demand the high pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt_reg <= '0;
    end else if (!select_n_sync) begin
      high_cnt_reg <= '0;
    end else if (high_cnt_reg != HIGH_TARGET) begin
      high_cnt_reg <= high_cnt_reg + 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      amd_pkg::AMD_WAIT_HIGH: begin
        if (high_cnt_reg == HIGH_TARGET) state_next = amd_pkg::AMD_FIRST;
      end
      amd_pkg::AMD_FIRST: begin
        if (conv_done) state_next = amd_pkg::AMD_RUN;
      end
      amd_pkg::AMD_RUN: begin
        state_next = amd_pkg::AMD_RUN;
      end
      default: begin
        state_next = amd_pkg::AMD_WAIT_HIGH;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= amd_pkg::AMD_WAIT_HIGH;
    end else begin
      state_reg <= state_next;
    end
  end

  assign first_done = conv_done && (state_reg == amd_pkg::AMD_FIRST);
  assign init_done  = (state_reg != amd_pkg::AMD_WAIT_HIGH);

  // the first word is dropped, later words are passed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_keep <= 1'b0;
    end else begin
      result_keep <= conv_done && (state_reg == amd_pkg::AMD_RUN);
    end
  end

  // sticky, write one to clear; a discard in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discarded_reg <= 1'b0;
    end else if (first_done) begin
      discarded_reg <= 1'b1;
    end else if (wr_en && hit_status && pstrb[0] && pwdata[amd_pkg::AMD_ST_DISCARDED]) begin
      discarded_reg <= 1'b0;
    end
  end

  // kept results, wraps at full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (conv_done && (state_reg == amd_pkg::AMD_RUN)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  first_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_done |=> !result_keep && (state_reg == amd_pkg::AMD_RUN) && discarded_reg)
    else $error("first result after power-up was not discarded");

  later_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_keep |-> $past(conv_done) && $past(state_reg) == amd_pkg::AMD_RUN)
    else $error("result kept without a later conversion");

  addr_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit_addr && pstrb[0] |=> ##1
      (sel_reg.pwr_dn == !$past(pwdata[0], 2)) &&
      (sel_reg.cmn_neg == ($past(pwdata[0], 2) && $past(pwdata[1], 2))))
    else $error("address bit order not kept");

  power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    !addr_reg.power_up_control |=> sel_reg.pwr_dn && sel_reg.pos == 8'h00 &&
      sel_reg.neg == 8'h00 && !sel_reg.cmn_neg)
    else $error("power-down left a channel connected");

  single_ch_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_reg.power_up_control && addr_reg.single_or_differential |=>
      sel_reg.cmn_neg && sel_reg.neg == 8'h00 &&
      sel_reg.pos == (8'h01 << {$past(addr_reg.group_select_high),
        $past(addr_reg.group_select_low), $past(addr_reg.odd_or_sign)}))
    else $error("single-ended channel decode wrong");

  diff_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_reg.power_up_control && !addr_reg.single_or_differential |=>
      !sel_reg.cmn_neg && $countones(sel_reg.pos) == 1 &&
      (sel_reg.pos | sel_reg.neg) == (8'h03 << {$past(addr_reg.group_select_high),
        $past(addr_reg.group_select_low), 1'b0}) &&
      ((sel_reg.pos[1] | sel_reg.pos[3] | sel_reg.pos[5] | sel_reg.pos[7]) ==
        $past(addr_reg.odd_or_sign)))
    else $error("differential pair decode wrong");

  first_cov_c: cover property (@(posedge pclk) disable iff (!presetn) first_done);
  keep_cov_c: cover property (@(posedge pclk) disable iff (!presetn) result_keep);
  diff_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    !sel_reg.pwr_dn && !sel_reg.cmn_neg && sel_reg.pos[7]);
  single_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
    sel_reg.cmn_neg && sel_reg.pos[7]);
  wait_cov_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(init_done));

  // own run length of the synchronised select, kept apart from the wait counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_run_reg <= '0;
    end else if (!select_n_sync) begin
      high_run_reg <= '0;
    end else if (high_run_reg != '1) begin
      high_run_reg <= high_run_reg + 1'b1;
    end
  end

  select_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(init_done) |-> $past(high_run_reg) >= HIGH_TARGET)
    else $error("select-high wait ended too early");

  no_early_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg != amd_pkg::AMD_RUN |=> !result_keep)
    else $error("result kept before the first conversion was dropped");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_keep |-> count_reg == $past(count_reg) + 1'b1)
    else $error("kept result not counted");

  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !result_keep |-> $stable(count_reg))
    else $error("count moved without a kept result");

endmodule // amd_top
`default_nettype wire

/* File: amd_dummy_unused.sv */
/*
 * intentionally empty.
 * assumes nothing.
 */

/* File: amd_host_model.sv */
/*
 * host-side model: drives the select pin and the end-of-conversion pulse.
 * assumes requests arrive on pclk from the bench: init_req as a one-cycle pulse, conv_req high for one cycle per conversion.
 */
`timescale 1ns/1ns
`default_nettype none
module amd_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       init_req,
  input  wire logic [7:0] high_len,
  input  wire logic       conv_req,
  output var  logic       select_n,
  output var  logic       conv_done
);
  logic [7:0] cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // select held low through supply ramp, then a high pulse of high_len cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_n <= 1'b0;
      cnt      <= 8'h00;
    end else if (init_req) begin
      select_n <= 1'b1;
      cnt      <= high_len;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else if (cnt == 8'h01) begin
      cnt      <= 8'h00;
      select_n <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the bench decides which results the host uses; the first is never counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done <= 1'b0;
    end else begin
      conv_done <= conv_req;
    end
  end
endmodule // amd_host_model
`default_nettype wire

/* File: adc_mux_address_decode_test.sv */
/*
 * self-checking bench for the channel-address decode block.
 * assumes the host model in its own file and the design package.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_mux_address_decode_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        init_req = 1'b0;
  logic [7:0]  high_len = 8'h00;
  logic        conv_req = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pos;
  logic [7:0]  neg;
  logic        cmn;
  logic        pd;
  logic        idn;
  logic        keep;
  logic        select_n;
  logic        conv_done;
  logic [31:0] rd;
  logic        err;
  logic        cd_q = 1'b0;
  logic [4:0]  av;
  int          err_count = 0;
  int          checked = 0;
  int          keeps = 0;
  int          r;

  always #5 pclk = ~pclk;

  amd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .select_n(select_n), .conv_done(conv_done),
    .chan_pos_en(pos), .chan_neg_en(neg), .common_terminal_neg(cmn),
    .powered_down(pd), .init_done(idn), .result_keep(keep));

  amd_host_model host_u (.pclk(pclk), .presetn(presetn), .init_req(init_req),
    .high_len(high_len), .conv_req(conv_req), .select_n(select_n), .conv_done(conv_done));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conv(input int n);
    repeat (n) begin
      @(posedge pclk);
      conv_req <= 1'b1;
    end
    @(posedge pclk);
    conv_req <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic sel_pulse(input logic [7:0] len);
    @(posedge pclk);
    high_len <= len;
    init_req <= 1'b1;
    @(posedge pclk);
    init_req <= 1'b0;
  endtask

  // reference decode: {pd, com, neg[7:0], pos[7:0]}
  function automatic logic [31:0] exp_sel(input logic [4:0] a);
    logic [2:0] p;
    p = {a[3], a[4], a[2]};
    if (!a[0]) return 32'h0002_0000;
    if (a[1]) return 32'h0001_0000 | (32'h1 << p);
    return (32'h1 << p) | (32'h100 << {a[3], a[4], ~a[2]});
  endfunction

  // a kept result must follow a conversion pulse by exactly one cycle
  always @(posedge pclk) begin
    if (keep === 1'b1) begin
      keeps++;
      chk({31'h0, cd_q}, 32'h1);
    end
    cd_q = conv_done;
  end

  initial begin
    #100000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    void'($urandom(74486));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({14'h0, pd, cmn, neg, pos}, 32'h0002_0000);
    apb(1'b0, amd_pkg::AMD_OFF_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    // conversions before the select pulse are ignored
    conv(2);
    chk(keeps, 0);
    sel_pulse(8'd20);
    repeat (40) @(posedge pclk);
    chk({31'h0, idn}, 32'h0);
    sel_pulse(8'd48);
    repeat (30) @(posedge pclk);
    chk({31'h0, idn}, 32'h0);
    for (int i = 0; i < 40 && idn !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, idn}, 32'h1);
    $display("test select pulse done");
    conv(1);
    chk(keeps, 0);
    apb(1'b0, amd_pkg::AMD_OFF_STATUS, 32'h0);
    chk(rd & 32'h5, 32'h5);
    conv(3);
    chk(keeps, 3);
    apb(1'b0, amd_pkg::AMD_OFF_COUNT, 32'h0);
    chk(rd & 32'hffff, 32'h3);
    // discarded flag clears on a write of one
    apb(1'b1, amd_pkg::AMD_OFF_STATUS, 32'h4);
    apb(1'b0, amd_pkg::AMD_OFF_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h1);
    $display("test discard done");
    r = $urandom % 32;
    for (int i = 0; i < 32; i++) begin
      av = 5'((i * 13 + r) % 32);
      apb(1'b1, amd_pkg::AMD_OFF_ADDR, ($urandom & 32'hffff_ffe0) | {27'h0, av});
      repeat (3) @(posedge pclk);
      chk({14'h0, pd, cmn, neg, pos}, exp_sel(av));
      apb(1'b0, amd_pkg::AMD_OFF_SELECT, 32'h0);
      chk(rd, exp_sel(av));
      apb(1'b0, amd_pkg::AMD_OFF_ADDR, 32'h0);
      chk(rd & 32'h1f, {27'h0, av});
    end
    $display("test decode done");
    // unmapped places answer with an error and zero data
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, amd_pkg::AMD_OFF_SELECT, 32'hffff_ffff);
    apb(1'b0, amd_pkg::AMD_OFF_SELECT, 32'h0);
    chk(rd, exp_sel(av));
    chk({31'h0, err}, 32'h0);
    $display("test refusal done");
    // a second reset demands the select-high pulse again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({13'h0, idn, pd, cmn, neg, pos}, 32'h0002_0000);
    chk({31'h0, pready}, 32'h1);
    apb(1'b0, amd_pkg::AMD_OFF_COUNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, amd_pkg::AMD_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule // adc_mux_address_decode_test
`default_nettype wire
